// ### core/cscr_pkg.sv
// Purpose: shared constants for the converter status and control register bank
// Assumes: 8-bit register port, byte offsets as seen by the serial host
// Notes: offsets, field positions, reset values and decode limits live here; assertions and the bench repeat some as literals
package cscr_pkg;
    // register offsets
    localparam logic [7:0] STATUS_FLAGS_OFS = 8'h10;
    localparam logic [7:0] FLAG_MASKS_OFS = 8'h11;
    localparam logic [7:0] LOOP_CONTROL_OFS = 8'h12;
    localparam logic [7:0] REFERENCE_LEVEL_OFS = 8'h13;

    // status and mask bit positions
    localparam int OVERCURRENT_BIT = 0;
    localparam int THERMAL_TRIP_BIT = 1;
    localparam int OUTPUT_SHORT_BIT = 2;
    localparam int OVERVOLTAGE_BIT = 3;
    localparam int IN_RANGE_BIT = 4;
    localparam int STATUS_BITS = 5;

    // loop_control field positions
    localparam int COMP_LSB = 5;
    localparam int RATE_LSB = 3;
    localparam int CURRENT_LIMIT_SEL_LSB = 0;

    // values after reset or shutdown
    localparam logic [7:0] STATUS_FLAGS_RST = 8'h00;
    localparam logic [7:0] FLAG_MASKS_RST = 8'h0F;
    localparam logic [2:0] COMP_SEL_RST = 3'h2;
    localparam logic [1:0] SWITCH_RATE_RST = 2'h2;
    localparam logic [2:0] CURRENT_LIMIT_RST = 3'h0;
    localparam logic [7:0] LOOP_CONTROL_RST = {COMP_SEL_RST, SWITCH_RATE_RST, CURRENT_LIMIT_RST};
    localparam logic [7:0] REFERENCE_LEVEL_RST = 8'h44;
    localparam logic [7:0] UNMAPPED_READ = 8'h00;

    // reference decode limits: linear span between these codes, clamped outside
    localparam logic [7:0] REF_CODE_LOW = 8'h3D;
    localparam logic [7:0] REF_CODE_HIGH = 8'hCC;
    localparam int REF_STEP_UV = 4900;
    localparam int REF_LOW_MV = 299;
    localparam int REF_HIGH_MV = 1000;

    // synchroniser depth for pin inputs
    localparam int SYNC_STAGES = 2;
endpackage

// ### core/cscr_ref_clamp.sv
// Purpose: decode the reference code into an effective clamped code and step index
// Assumes: purely combinational, registered by the caller
// Notes: codes below the linear span act as its lowest code, above as its highest
`timescale 1ns/1ns
module cscr_ref_clamp (
    // raw field
    input wire logic [7:0] ref_code,
    // decoded level
    output logic [7:0] eff_code,
    output logic [7:0] step_index
);
    // clamp into the linear span, then count steps above its floor
    always_comb begin
        if (ref_code < cscr_pkg::REF_CODE_LOW) begin
            eff_code = cscr_pkg::REF_CODE_LOW;
        end else if (ref_code > cscr_pkg::REF_CODE_HIGH) begin
            eff_code = cscr_pkg::REF_CODE_HIGH;
        end else begin
            eff_code = ref_code;
        end
        step_index = eff_code - cscr_pkg::REF_CODE_LOW;
    end
endmodule

// ### core/cscr_regs.sv
// Purpose: status, mask and control registers of the buck-boost converter
// Assumes: serial engine presents decoded reads and writes on sys_clk
// Notes: fault and level inputs come from analog pins and are synchronised first
`timescale 1ns/1ns

// Functional notes
// - status bits 7 to 5 read zero
// - status bit 4 shows output in range
// - status bit 3 latches overvoltage detection
// - status bit 2 latches hard-short shutoff
// - status bit 1 latches thermal shutoff
// - status bit 0 latches overcurrent shutoff
// - mask bit 4 hides in-range, resets zero
// - mask bits 3..0 hide faults, reset one
// - loop bits 7:5 compensation, default 010
// - loop bits 4:3 switch rate, default 10
// - loop bits 2:0 current limit, default 000
// - codes 00..3C clamp to lowest level
// - codes CD..FF clamp high, reset 44
// - shutdown conditions restore all defaults
module cscr_regs (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rst_b,
    // register port from the serial engine
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // analog status pins
    input wire logic output_in_range,
    input wire logic overvoltage_det,
    input wire logic output_short_det,
    input wire logic thermal_trip_det,
    input wire logic overcurrent_det,
    // shutdown condition pins
    input wire logic io_supply_valid,
    input wire logic input_below_lockout,
    input wire logic enable_in,
    // settings toward the regulator
    output logic [2:0] comp_sel,
    output logic [1:0] switch_rate_sel,
    output logic [2:0] current_limit_sel,
    output logic [7:0] ref_eff_code,
    output logic [7:0] ref_step_index,
    // open-drain alert pin
    output logic alert_pin_o,
    output logic alert_pin_oe
);
    typedef struct packed {
        logic [4:0] stat_meta;
        logic [4:0] stat_sync;
        logic [2:0] sd_meta;
        logic [2:0] sd_sync;
        logic [4:0] flags;
        logic [4:0] masks;
        logic [7:0] loop_ctl;
        logic [7:0] ref_lvl;
        logic [7:0] ref_eff;
        logic [7:0] ref_step;
        logic [7:0] rdata;
        logic alert_oe;
    } cscr_state_s;

    cscr_state_s st_ff;
    cscr_state_s nxt_st;

    logic [4:0] stat_pins;
    logic [2:0] sd_pins;
    logic shutdown;
    logic [7:0] status_word;
    logic [7:0] dec_eff;
    logic [7:0] dec_step;

    // gather pins in status bit order
    assign stat_pins = {output_in_range, overvoltage_det, output_short_det, thermal_trip_det, overcurrent_det};
    assign sd_pins = {io_supply_valid, input_below_lockout, enable_in};

    // any synchronised shutdown condition returns the bank to defaults
    assign shutdown = !st_ff.sd_sync[2] || st_ff.sd_sync[1] || !st_ff.sd_sync[0];

    // status word as seen by the host, upper bits tied low
    assign status_word = {3'h0, st_ff.flags};

    // reference decoder on the stored code
    cscr_ref_clamp u_ref_clamp (
        .ref_code(st_ff.ref_lvl),
        .eff_code(dec_eff),
        .step_index(dec_step)
    );

    // read mux over the four mapped offsets
    // unmapped offsets read as zero so a stray pointer never shows stale data
    function automatic logic [7:0] read_mux(input logic [7:0] addr, input cscr_state_s s,
                                            input logic [7:0] stat);
        case (addr)
            cscr_pkg::STATUS_FLAGS_OFS: read_mux = stat;
            cscr_pkg::FLAG_MASKS_OFS: read_mux = {3'h0, s.masks};
            cscr_pkg::LOOP_CONTROL_OFS: read_mux = s.loop_ctl;
            cscr_pkg::REFERENCE_LEVEL_OFS: read_mux = s.ref_lvl;
            default: read_mux = cscr_pkg::UNMAPPED_READ;
        endcase
    endfunction

    // next-state logic for the whole bank
    always_comb begin
        nxt_st = st_ff;
        // two-stage synchronisers, first stage feeds only the second
        nxt_st.stat_meta = stat_pins;
        nxt_st.stat_sync = st_ff.stat_meta;
        nxt_st.sd_meta = sd_pins;
        nxt_st.sd_sync = st_ff.sd_meta;
        // in-range bit follows the level, fault bits latch until shutdown
        nxt_st.flags[cscr_pkg::IN_RANGE_BIT] = st_ff.stat_sync[cscr_pkg::IN_RANGE_BIT];
        nxt_st.flags[cscr_pkg::OVERVOLTAGE_BIT] = st_ff.flags[cscr_pkg::OVERVOLTAGE_BIT]
            | st_ff.stat_sync[cscr_pkg::OVERVOLTAGE_BIT];
        nxt_st.flags[cscr_pkg::OUTPUT_SHORT_BIT] = st_ff.flags[cscr_pkg::OUTPUT_SHORT_BIT]
            | st_ff.stat_sync[cscr_pkg::OUTPUT_SHORT_BIT];
        nxt_st.flags[cscr_pkg::THERMAL_TRIP_BIT] = st_ff.flags[cscr_pkg::THERMAL_TRIP_BIT]
            | st_ff.stat_sync[cscr_pkg::THERMAL_TRIP_BIT];
        nxt_st.flags[cscr_pkg::OVERCURRENT_BIT] = st_ff.flags[cscr_pkg::OVERCURRENT_BIT]
            | st_ff.stat_sync[cscr_pkg::OVERCURRENT_BIT];
        // host writes; the status offset has no write path at all
        if (reg_wr) begin
            case (reg_addr)
                cscr_pkg::FLAG_MASKS_OFS: nxt_st.masks = reg_wdata[4:0];
                cscr_pkg::LOOP_CONTROL_OFS: nxt_st.loop_ctl = reg_wdata;
                cscr_pkg::REFERENCE_LEVEL_OFS: nxt_st.ref_lvl = reg_wdata;
                default: nxt_st.masks = st_ff.masks;
            endcase
        end
        // registered read data, held until the next read
        if (reg_rd) begin
            nxt_st.rdata = read_mux(reg_addr, st_ff, status_word);
        end
        // decoded reference level toward the regulator
        nxt_st.ref_eff = dec_eff;
        nxt_st.ref_step = dec_step;
        // alert pulls low while any unmasked status bit is active
        nxt_st.alert_oe = |(st_ff.flags & ~st_ff.masks);
        // shutdown overrides every configuration and latched flag
        // it sits last so it beats a write or a fault arriving in the same cycle
        if (shutdown) begin
            nxt_st.flags = cscr_pkg::STATUS_FLAGS_RST[4:0];
            nxt_st.masks = cscr_pkg::FLAG_MASKS_RST[4:0];
            nxt_st.loop_ctl = cscr_pkg::LOOP_CONTROL_RST;
            nxt_st.ref_lvl = cscr_pkg::REFERENCE_LEVEL_RST;
        end
    end

    // state register with synchronous active-low reset
    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            // synchronisers start powered: supply valid, no lockout, enabled
            st_ff <= '{stat_meta: 5'h00, stat_sync: 5'h00, sd_meta: 3'h5, sd_sync: 3'h5,
                       flags: cscr_pkg::STATUS_FLAGS_RST[4:0], masks: cscr_pkg::FLAG_MASKS_RST[4:0],
                       loop_ctl: cscr_pkg::LOOP_CONTROL_RST, ref_lvl: cscr_pkg::REFERENCE_LEVEL_RST,
                       ref_eff: cscr_pkg::REFERENCE_LEVEL_RST,
                       ref_step: cscr_pkg::REFERENCE_LEVEL_RST - cscr_pkg::REF_CODE_LOW,
                       rdata: cscr_pkg::UNMAPPED_READ, alert_oe: 1'b0};
        end else begin
            st_ff <= nxt_st;
        end
    end

    // outputs straight from state flops
    assign reg_rdata = st_ff.rdata;
    assign comp_sel = st_ff.loop_ctl[cscr_pkg::COMP_LSB +: 3];
    assign switch_rate_sel = st_ff.loop_ctl[cscr_pkg::RATE_LSB +: 2];
    assign current_limit_sel = st_ff.loop_ctl[cscr_pkg::CURRENT_LIMIT_SEL_LSB +: 3];
    assign ref_eff_code = st_ff.ref_eff;
    assign ref_step_index = st_ff.ref_step;
    assign alert_pin_o = st_ff.rdata[7] & 1'b0; // open drain only ever pulls low
    assign alert_pin_oe = st_ff.alert_oe;

    // reading the status register never shows the reserved bits set
    AST_RSVD_ZERO: assert property (@(posedge sys_clk) disable iff (!rst_b)
        reg_rd && reg_addr == cscr_pkg::STATUS_FLAGS_OFS |=> reg_rdata[7:5] == 3'h0)
        else $error("status reserved bits read nonzero");

    // in-range bit trails the synchronised level by one edge
    AST_IN_RANGE: assert property (@(posedge sys_clk) disable iff (!rst_b)
        !shutdown |=> st_ff.flags[4] == $past(st_ff.stat_sync[4]))
        else $error("in-range bit does not follow its input");

    // overvoltage flag stays set until shutdown
    AST_OVP_HOLD: assert property (@(posedge sys_clk) disable iff (!rst_b)
        st_ff.flags[3] && !shutdown |=> st_ff.flags[3])
        else $error("overvoltage flag dropped without shutdown");

    // a short held at the pin shows in the status word within three edges
    AST_SHORT_SET: assert property (@(posedge sys_clk) disable iff (!rst_b)
        output_short_det [*3] ##0 !shutdown [*3] |=> st_ff.flags[2])
        else $error("hard short not latched");

    // thermal flag sets one edge after its synchronised input
    AST_THERMAL_SET: assert property (@(posedge sys_clk) disable iff (!rst_b)
        st_ff.stat_sync[1] && !shutdown |=> st_ff.flags[1])
        else $error("thermal flag not latched");

    // overcurrent flag only rises from a synchronised overcurrent
    AST_OC_CAUSE: assert property (@(posedge sys_clk) disable iff (!rst_b)
        $rose(st_ff.flags[0]) |-> $past(st_ff.stat_sync[0]))
        else $error("overcurrent flag set without cause");

    // shutdown restores masks and loop settings on the next edge
    AST_SHUTDOWN_DEFAULTS: assert property (@(posedge sys_clk) disable iff (!rst_b)
        shutdown |=> st_ff.masks == 5'h0F && st_ff.loop_ctl == 8'h50 && st_ff.ref_lvl == 8'h44
        && st_ff.flags == 5'h00)
        else $error("shutdown did not restore defaults");

    // a mask write lands one edge later
    AST_MASK_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_b)
        reg_wr && reg_addr == cscr_pkg::FLAG_MASKS_OFS && !shutdown |=> st_ff.masks == $past(reg_wdata[4:0]))
        else $error("mask write lost");

    // a loop write reaches the three select outputs together
    AST_LOOP_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_b)
        reg_wr && reg_addr == cscr_pkg::LOOP_CONTROL_OFS && !shutdown
        |=> {comp_sel, switch_rate_sel, current_limit_sel} == $past(reg_wdata))
        else $error("loop control write lost");

    // effective reference code always lies inside the linear span
    AST_REF_CLAMP: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ##1 (ref_eff_code >= 8'h3D && ref_eff_code <= 8'hCC && ref_step_index <= 8'h8F))
        else $error("reference code outside clamp range");

    // a write at the status offset leaves every fault flag as the inputs make it
    AST_STATUS_RO: assert property (@(posedge sys_clk) disable iff (!rst_b)
        reg_wr && reg_addr == cscr_pkg::STATUS_FLAGS_OFS && !shutdown
        |=> st_ff.flags[3:0] == ($past(st_ff.flags[3:0]) | $past(st_ff.stat_sync[3:0])))
        else $error("status register changed by a write");

    // alert pin drive follows the unmasked status one edge later
    AST_ALERT: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ##1 alert_pin_oe == $past(|(st_ff.flags & ~st_ff.masks)))
        else $error("alert pin does not match unmasked status");

    // a code inside the linear span reaches the regulator unchanged two edges later
    AST_REF_LINEAR: assert property (@(posedge sys_clk) disable iff (!rst_b)
        reg_wr && reg_addr == cscr_pkg::REFERENCE_LEVEL_OFS && !shutdown
        && reg_wdata >= cscr_pkg::REF_CODE_LOW && reg_wdata <= cscr_pkg::REF_CODE_HIGH
        |=> ##1 ref_eff_code == $past(reg_wdata, 2))
        else $error("reference code inside the span was altered");

    // a code below the span acts as its lowest code
    AST_REF_LOW: assert property (@(posedge sys_clk) disable iff (!rst_b)
        reg_wr && reg_addr == cscr_pkg::REFERENCE_LEVEL_OFS && !shutdown && reg_wdata < cscr_pkg::REF_CODE_LOW
        |=> ##1 ref_eff_code == cscr_pkg::REF_CODE_LOW && ref_step_index == 8'h00)
        else $error("low reference code not clamped");

    // a code above the span acts as its highest code
    AST_REF_HIGH: assert property (@(posedge sys_clk) disable iff (!rst_b)
        reg_wr && reg_addr == cscr_pkg::REFERENCE_LEVEL_OFS && !shutdown
        && reg_wdata > cscr_pkg::REF_CODE_HIGH
        |=> ##1 ref_eff_code == cscr_pkg::REF_CODE_HIGH && ref_step_index == 8'h8F)
        else $error("high reference code not clamped");

    // step index counts steps above the floor of the span
    AST_REF_STEP: assert property (@(posedge sys_clk) disable iff (!rst_b)
        ref_step_index == ref_eff_code - cscr_pkg::REF_CODE_LOW)
        else $error("reference step index inconsistent");

    // unmasked in-range status drives the alert pin on the next edge
    AST_IN_RANGE_MASK: assert property (@(posedge sys_clk) disable iff (!rst_b)
        st_ff.flags[cscr_pkg::IN_RANGE_BIT] && !st_ff.masks[cscr_pkg::IN_RANGE_BIT] |=> alert_pin_oe)
        else $error("unmasked in-range status not reported");

    // fully masked status leaves the alert pin released
    AST_MASKED_QUIET: assert property (@(posedge sys_clk) disable iff (!rst_b)
        (st_ff.flags & ~st_ff.masks) == 5'h00 |=> !alert_pin_oe)
        else $error("masked status still drives the alert pin");

    // shutdown puts the compensation, rate and limit selects back to defaults
    AST_LOOP_DEFAULTS: assert property (@(posedge sys_clk) disable iff (!rst_b)
        shutdown |=> comp_sel == cscr_pkg::COMP_SEL_RST && switch_rate_sel == cscr_pkg::SWITCH_RATE_RST
        && current_limit_sel == cscr_pkg::CURRENT_LIMIT_RST)
        else $error("loop selects not restored by shutdown");

    // a current limit written while powered reaches its select output
    AST_CURRENT_LIMIT_SEL_WRITE: assert property (@(posedge sys_clk) disable iff (!rst_b)
        reg_wr && reg_addr == cscr_pkg::LOOP_CONTROL_OFS && !shutdown
        |=> current_limit_sel == $past(reg_wdata[2:0]))
        else $error("current limit write lost");

    // writes at the status offset or any unmapped offset leave the settings alone
    AST_WRITE_IGNORED: assert property (@(posedge sys_clk) disable iff (!rst_b)
        reg_wr && reg_addr != cscr_pkg::FLAG_MASKS_OFS && reg_addr != cscr_pkg::LOOP_CONTROL_OFS
        && reg_addr != cscr_pkg::REFERENCE_LEVEL_OFS && !shutdown
        |=> $stable(st_ff.masks) && $stable(st_ff.loop_ctl) && $stable(st_ff.ref_lvl))
        else $error("write to a read-only offset changed a setting");

    // mask reads return the stored mask with reserved bits low
    AST_MASK_READ: assert property (@(posedge sys_clk) disable iff (!rst_b)
        reg_rd && reg_addr == cscr_pkg::FLAG_MASKS_OFS |=> reg_rdata == {3'h0, $past(st_ff.masks)})
        else $error("mask read data wrong");
endmodule

// ### dv/cscr_host_model.sv
// Purpose: serial host model that issues single-byte reads and writes to the register bank
// Assumes: requests launch at the falling edge and are taken at the next rising edge
// Notes: released address and data lines show the inverse of their last value
`timescale 1ns/1ns
module cscr_host_model (
    // clock
    input wire logic sys_clk,
    // register port
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic [7:0] reg_wdata,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    // idle state of the port
    initial begin
        reg_addr = 8'hEE;
        reg_wr = 1'b0;
        reg_wdata = 8'h5A;
        reg_rd = 1'b0;
    end

    // one write, held across one rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        if (a == cscr_pkg::LOOP_CONTROL_OFS && d[4:3] == 2'h3) d[4:3] = 2'h2; // never send reserved rate
        @(negedge sys_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge sys_clk);
        reg_wr = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask

    // one read, data taken once the taking edge has landed
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge sys_clk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        d = reg_rdata;
    endtask
endmodule

// ### dv/cscr_regs_bench.sv
// Purpose: self-checking bench of the converter status and control register bank
// Assumes: inputs change at the falling edge, status pins settle within five cycles
// Notes: random values come from an xorshift generator with a fixed seed
`timescale 1ns/1ns
module cscr_regs_bench;
    logic sys_clk = 1'b0;
    logic rst_b = 1'b0;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, ref_eff_code, ref_step_index, rv, ex, m;
    logic reg_wr, reg_rd, alert_pin_o, alert_pin_oe;
    logic [4:0] det = 5'h00; // in range, overvoltage, short, thermal, overcurrent
    logic [2:0] pwr = 3'b101; // supply valid, below lockout, enable
    logic [2:0] comp_sel, current_limit_sel;
    logic [1:0] switch_rate_sel;
    logic [31:0] seed = 32'hbc097579;
    logic [7:0] corner [6] = '{8'h00, 8'h3C, 8'h3D, 8'hCC, 8'hCD, 8'hFF};
    int fail_count = 0;
    int n_tests = 0;

    // clock
    always #50 sys_clk = ~sys_clk;

    cscr_host_model host (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata));
    cscr_regs dut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .output_in_range(det[4]), .overvoltage_det(det[3]),
        .output_short_det(det[2]), .thermal_trip_det(det[1]), .overcurrent_det(det[0]),
        .io_supply_valid(pwr[2]), .input_below_lockout(pwr[1]), .enable_in(pwr[0]), .comp_sel(comp_sel),
        .switch_rate_sel(switch_rate_sel), .current_limit_sel(current_limit_sel), .ref_eff_code(ref_eff_code),
        .ref_step_index(ref_step_index), .alert_pin_o(alert_pin_o), .alert_pin_oe(alert_pin_oe));

    // next random word
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    // expected effective reference code
    function automatic logic [7:0] clamp(input logic [7:0] c);
        if (c < 8'h3D) return 8'h3D;
        if (c > 8'hCC) return 8'hCC;
        return c;
    endfunction

    // compare and count
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // read a register and compare
    task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
        host.rd(a, rv);
        chk(rv, e);
    endtask

    // verdict
    task automatic final_report();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // hang guard
    initial begin
        repeat (20000) @(posedge sys_clk);
        fail_count++;
        final_report();
    end

    // main sequence
    initial begin
        repeat (6) @(negedge sys_clk);
        rst_b = 1'b1;
        rdchk(8'h10, 8'h00);
        rdchk(8'h11, 8'h0F);
        rdchk(8'h12, 8'h50);
        rdchk(8'h13, 8'h44);
        rdchk(8'h20, 8'h00);
        chk(ref_step_index, 8'h07);
        $display("reset values done");
        for (int i = 0; i < 26; i++) begin
            seed = xs(seed);
            ex = (i < 6) ? corner[i] : seed[7:0];
            host.wr(8'h13, ex);
            rdchk(8'h13, ex);
            chk(ref_eff_code, clamp(ex));
            chk(ref_step_index, clamp(ex) - 8'h3D);
            ex = seed[15:8];
            ex[4] = ex[4] & ~ex[3];
            host.wr(8'h12, ex);
            rdchk(8'h12, ex);
            chk({comp_sel, switch_rate_sel, current_limit_sel}, ex);
            host.wr(8'h11, seed[23:16]);
            rdchk(8'h11, seed[23:16] & 8'h1F);
            host.wr(8'h10, seed[31:24]);
            rdchk(8'h10, 8'h00);
        end
        $display("field writes done");
        host.wr(8'h11, 8'h1F);
        for (int b = 0; b < 5; b++) begin
            det = 5'h01 << b;
            repeat (5) @(negedge sys_clk);
            rdchk(8'h10, (8'h02 << b) - 8'h01);
            chk({7'h00, alert_pin_oe}, 8'h00);
            m = 8'h1F ^ (8'h01 << b);
            host.wr(8'h11, m);
            repeat (2) @(negedge sys_clk);
            chk({6'h00, alert_pin_oe, alert_pin_o}, 8'h02);
            host.wr(8'h11, 8'h1F);
        end
        det = 5'h00;
        repeat (5) @(negedge sys_clk);
        rdchk(8'h10, 8'h0F);
        $display("status pins done");
        for (int k = 0; k < 3; k++) begin
            det = 5'h08;
            host.wr(8'h12, 8'h0F);
            host.wr(8'h11, 8'h10);
            det = 5'h00;
            rdchk(8'h12, 8'h0F);
            rdchk(8'h10, (k == 0) ? 8'h0F : 8'h08);
            chk({7'h00, alert_pin_oe}, 8'h01);
            pwr = 3'b101 ^ (3'b001 << k);
            repeat (5) @(negedge sys_clk);
            host.wr(8'h13, 8'hAA);
            pwr = 3'b101;
            repeat (5) @(negedge sys_clk);
            rdchk(8'h10, 8'h00);
            rdchk(8'h11, 8'h0F);
            rdchk(8'h12, 8'h50);
            rdchk(8'h13, 8'h44);
        end
        $display("shutdown done");
        final_report();
    end
endmodule
